// File: common/ccrf_pkg.sv
// Constants and types shared by the core register set and condition-code logic.
//
// Summary of operation
// - Sixteen-bit program counter gives next fetch address.
// - Sixteen-bit accumulator; byte operations use low byte.
// - Sixteen-bit temporary accumulator is second operand.
// - Index register offsets operand addresses.
// - Extra pointer holds a memory address.
// - Stack pointer addresses the current stack location.
// - Status word: upper bank pointer, lower flags.
// - Half-carry flags carry between bits three, four.
// - Interrupt enable flag gates interrupts; reset clears.
// - Two-bit level; only stronger requests are serviced.
// - Negative flag copies result most significant bit.
// - Zero flag set on zero result.
// - Overflow flag set on signed overflow.
// - Carry flag from bit seven, or bit fifteen for words; shifts load it.
// - Thirty-two banks of eight byte registers.
// - One 64 KB space: I/O, data, program, vectors.
package ccrf_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses on the bus).
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_PC     = 8'h00;
  localparam logic [7:0] OFS_ACC    = 8'h04;
  localparam logic [7:0] OFS_TMP    = 8'h08;
  localparam logic [7:0] OFS_IDX    = 8'h0c;
  localparam logic [7:0] OFS_EXP    = 8'h10;
  localparam logic [7:0] OFS_SP     = 8'h14;
  localparam logic [7:0] OFS_PSW    = 8'h18;
  localparam logic [7:0] OFS_CMD    = 8'h1c;
  localparam logic [7:0] OFS_GSEL   = 8'h20;
  localparam logic [7:0] OFS_GDATA  = 8'h24;
  localparam logic [7:0] OFS_GPHYS  = 8'h28;
  localparam logic [7:0] OFS_MAPQ   = 8'h2c;
  localparam logic [7:0] OFS_STATUS = 8'h30;

  // ----------------------------------------------------------------------
  // Condition-code byte field positions.
  // ----------------------------------------------------------------------
  localparam int CC_H   = 7;
  localparam int CC_I   = 6;
  localparam int CC_IL1 = 5;
  localparam int CC_IL0 = 4;
  localparam int CC_N   = 3;
  localparam int CC_Z   = 2;
  localparam int CC_V   = 1;
  localparam int CC_C   = 0;

  // Command register fields.
  localparam int CMD_BYTE = 8;

  // ----------------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------------
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0]  RST_BANK = 8'h00;
  localparam logic [7:0]  RST_CC   = 8'h30;  // Interrupts off, weakest level.

  // ----------------------------------------------------------------------
  // General register bank geometry and physical placement.
  // ----------------------------------------------------------------------
  localparam int          GPR_PER_BANK = 8;
  localparam int          GPR_BANKS    = 32;
  localparam logic [15:0] GPR_BASE     = 16'h0100;

  // ----------------------------------------------------------------------
  // Address-space region limits (first address of each region).
  // ----------------------------------------------------------------------
  localparam logic [15:0] MAP_DATA_LO = 16'h0080;
  localparam logic [15:0] MAP_PROG_LO = 16'h4000;
  localparam logic [15:0] MAP_VEC_LO  = 16'hffc0;

  typedef enum logic [1:0] {
    CCRF_REG_IO, CCRF_REG_DATA, CCRF_REG_PROG, CCRF_REG_VEC
  } ccrf_region_t;

  // Operations started by the command register.
  typedef enum logic [3:0] {
    CCRF_OP_NOP, CCRF_OP_ADD, CCRF_OP_SUB, CCRF_OP_CMP, CCRF_OP_AND,
    CCRF_OP_OR, CCRF_OP_XOR, CCRF_OP_SHL, CCRF_OP_SHR, CCRF_OP_STEP
  } ccrf_op_t;

endpackage : ccrf_pkg

// File: src/ccrf_alu.sv
// Combinational calculator that produces a result and the arithmetic flags.
`timescale 1ns/100ps
module ccrf_alu (
  // Operands and operation
  input  wire logic [15:0]      op_a,
  input  wire logic [15:0]      op_b,
  input  wire ccrf_pkg::ccrf_op_t op_code,
  input  wire logic             byte_mode,
  input  wire logic             carry_in,
  // Result and flags
  output logic      [15:0]      result,
  output logic                  flag_h,
  output logic                  flag_n,
  output logic                  flag_z,
  output logic                  flag_v,
  output logic                  flag_c,
  output logic                  arith
);

  // ----------------------------------------------------------------------
  // Result and flag computation.
  // ----------------------------------------------------------------------
  // Byte operations see only the low bytes so that upper bits cannot leak
  // into any flag.
  always_comb begin
    logic [16:0] sum;
    logic [15:0] a;
    logic [15:0] b;
    logic [4:0]  nib;
    logic        top;
    sum    = 17'h00000;
    a      = byte_mode ? {8'h00, op_a[7:0]} : op_a;
    b      = byte_mode ? {8'h00, op_b[7:0]} : op_b;
    nib    = 5'h00;
    top    = 1'b0;
    arith  = 1'b0;
    flag_c = carry_in;
    flag_v = 1'b0;
    case (op_code)
      ccrf_pkg::CCRF_OP_ADD: begin
        sum   = {1'b0, a} + {1'b0, b};
        nib   = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        arith = 1'b1;
      end
      ccrf_pkg::CCRF_OP_SUB, ccrf_pkg::CCRF_OP_CMP: begin
        sum   = {1'b0, a} - {1'b0, b};
        nib   = {1'b0, a[3:0]} - {1'b0, b[3:0]};
        arith = 1'b1;
      end
      ccrf_pkg::CCRF_OP_AND: sum = {1'b0, a & b};
      ccrf_pkg::CCRF_OP_OR:  sum = {1'b0, a | b};
      ccrf_pkg::CCRF_OP_XOR: sum = {1'b0, a ^ b};
      ccrf_pkg::CCRF_OP_SHL: begin
        sum    = {1'b0, a[14:0], carry_in};
        flag_c = byte_mode ? a[7] : a[15];
      end
      ccrf_pkg::CCRF_OP_SHR: begin
        sum    = byte_mode ? {9'h000, carry_in, a[7:1]} : {1'b0, carry_in, a[15:1]};
        flag_c = a[0];
      end
      default: sum = {1'b0, a};
    endcase
    result = byte_mode ? {8'h00, sum[7:0]} : sum[15:0];
    top    = byte_mode ? result[7] : result[15];
    if (arith) begin
      // Carry or borrow out of the operand width: bit 7 for bytes.
      flag_c = byte_mode ? (a[8] ^ b[8] ^ sum[8]) : sum[16];
      flag_v = byte_mode ? ((a[7] ^ top) & ((op_code == ccrf_pkg::CCRF_OP_ADD) ?
                 ~(a[7] ^ b[7]) : (a[7] ^ b[7])))
               : ((a[15] ^ top) & ((op_code == ccrf_pkg::CCRF_OP_ADD) ?
                 ~(a[15] ^ b[15]) : (a[15] ^ b[15])));
    end
    flag_h = nib[4];
    flag_n = top;
    flag_z = (result == 16'h0000);
  end

endmodule : ccrf_alu

// File: src/ccrf_gpr_bank.sv
// Memory-resident banks of byte-wide general registers.
`timescale 1ns/100ps
module ccrf_gpr_bank #(
  parameter int BANKS    = ccrf_pkg::GPR_BANKS,
  parameter int PER_BANK = ccrf_pkg::GPR_PER_BANK
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Access port
  input  wire logic [7:0]  bank,
  input  wire logic [2:0]  reg_num,
  input  wire logic        wr_en,
  input  wire logic [7:0]  wr_data,
  output logic      [7:0]  rd_data,
  output logic      [15:0] phys_addr
);

  initial begin
    if (BANKS != 32 || PER_BANK != 8) begin
      $error("ccrf_gpr_bank: only 32 banks of 8 registers are supported.");
    end
  end

  // The array is the register file itself; no reset, as it stands for RAM.
  logic [7:0] mem [BANKS*PER_BANK];
  logic [7:0] index;

  // ----------------------------------------------------------------------
  // Physical placement.
  // ----------------------------------------------------------------------
  // Bank pointer selects the bank, register number selects the byte.
  assign index     = {bank[4:0], reg_num};
  assign phys_addr = ccrf_pkg::GPR_BASE + {8'h00, index};
  assign rd_data   = mem[index];

  // Byte write into the selected bank.
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[index] <= wr_data;
    end
  end

endmodule : ccrf_gpr_bank

// File: src/ccrf_core.sv
// Dedicated register set, status word and flag logic behind an APB slave.
`timescale 1ns/100ps
module ccrf_core (
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB request
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  // APB answer
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt request to be judged
  input  wire logic        irq_req,
  input  wire logic [1:0]  irq_level,
  output logic             irq_accept,
  // Addresses presented to memory
  output logic      [15:0] fetch_addr,
  output logic      [15:0] operand_addr,
  output logic      [15:0] ptr_addr,
  output logic      [15:0] stack_addr
);

  // ----------------------------------------------------------------------
  // Architectural state.
  // ----------------------------------------------------------------------
  logic [15:0] pc;
  logic [15:0] acc;
  logic [15:0] tmp;
  logic [15:0] index_reg;
  logic [15:0] extra_pointer_reg;
  logic [15:0] sp;
  logic [7:0]  bank_pointer;
  logic [7:0]  condition_code_byte;
  logic [2:0]  gpr_sel;
  logic [15:0] map_query;
  logic [15:0] next_pc;
  logic [15:0] next_acc;
  logic [15:0] next_tmp;
  logic [15:0] next_index_reg;
  logic [15:0] next_extra_pointer_reg;
  logic [15:0] next_sp;
  logic [7:0]  next_bank_pointer;
  logic [7:0]  next_condition_code_byte;
  logic [2:0]  next_gpr_sel;
  logic [15:0] next_map_query;
  logic [15:0] program_status_word;

  // Bus answer state.
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        next_irq_accept;
  logic [15:0] next_operand_addr;

  // Bus phase decode.
  logic        setup;
  logic        access_wr;
  logic        mapped;
  logic        full_word;

  // Calculator connections.
  ccrf_pkg::ccrf_op_t cmd_op;
  logic        cmd_byte;
  logic        cmd_go;
  logic [15:0] alu_result;
  logic        alu_h;
  logic        alu_n;
  logic        alu_z;
  logic        alu_v;
  logic        alu_c;
  logic        alu_arith;

  // General register connections.
  logic        gpr_wr;
  logic [7:0]  gpr_rd;
  logic [15:0] gpr_phys;

  ccrf_pkg::ccrf_region_t region;

  // ----------------------------------------------------------------------
  // Status word view.
  // ----------------------------------------------------------------------
  // Upper byte is the bank pointer, lower byte the condition codes.
  assign program_status_word = {bank_pointer, condition_code_byte};

  // ----------------------------------------------------------------------
  // Bus decode.
  // ----------------------------------------------------------------------
  // The answer is prepared in the setup cycle so that prdata and pready can
  // come from flip-flops; pready is high in the first access cycle, so no wait state.
  assign setup     = psel & ~penable;
  assign access_wr = psel & penable & pready & pwrite & ~pslverr;
  assign full_word = (pstrb == 4'hf);
  assign cmd_op    = ccrf_pkg::ccrf_op_t'(pwdata[3:0]);
  assign cmd_byte  = pwdata[ccrf_pkg::CMD_BYTE];
  assign cmd_go    = access_wr & (paddr == ccrf_pkg::OFS_CMD);
  assign gpr_wr    = access_wr & (paddr == ccrf_pkg::OFS_GDATA);

  always_comb begin
    case (paddr)
      ccrf_pkg::OFS_PC, ccrf_pkg::OFS_ACC, ccrf_pkg::OFS_TMP, ccrf_pkg::OFS_IDX,
      ccrf_pkg::OFS_EXP, ccrf_pkg::OFS_SP, ccrf_pkg::OFS_PSW, ccrf_pkg::OFS_CMD,
      ccrf_pkg::OFS_GSEL, ccrf_pkg::OFS_GDATA, ccrf_pkg::OFS_MAPQ: mapped = 1'b1;
      ccrf_pkg::OFS_GPHYS, ccrf_pkg::OFS_STATUS: mapped = ~pwrite;
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Address-space classification of the queried address.
  // ----------------------------------------------------------------------
  always_comb begin
    if (map_query >= ccrf_pkg::MAP_VEC_LO) begin
      region = ccrf_pkg::CCRF_REG_VEC;
    end else if (map_query >= ccrf_pkg::MAP_PROG_LO) begin
      region = ccrf_pkg::CCRF_REG_PROG;
    end else if (map_query >= ccrf_pkg::MAP_DATA_LO) begin
      region = ccrf_pkg::CCRF_REG_DATA;
    end else begin
      region = ccrf_pkg::CCRF_REG_IO;
    end
  end

  // ----------------------------------------------------------------------
  // Calculator and register banks.
  // ----------------------------------------------------------------------
  ccrf_alu u_alu (
    .op_a      (acc),
    .op_b      (tmp),
    .op_code   (cmd_op),
    .byte_mode (cmd_byte),
    .carry_in  (condition_code_byte[ccrf_pkg::CC_C]),
    .result    (alu_result),
    .flag_h    (alu_h),
    .flag_n    (alu_n),
    .flag_z    (alu_z),
    .flag_v    (alu_v),
    .flag_c    (alu_c),
    .arith     (alu_arith)
  );

  ccrf_gpr_bank u_gpr (
    .pclk      (pclk),
    .presetn   (presetn),
    .bank      (bank_pointer),
    .reg_num   (gpr_sel),
    .wr_en     (gpr_wr),
    .wr_data   (pwdata[7:0]),
    .rd_data   (gpr_rd),
    .phys_addr (gpr_phys)
  );

  // ----------------------------------------------------------------------
  // Next values of the register set.
  // ----------------------------------------------------------------------
  // Partial writes are refused as errors so a half-written pointer is never seen.
  always_comb begin
    next_pc                  = pc;
    next_acc                 = acc;
    next_tmp                 = tmp;
    next_index_reg           = index_reg;
    next_extra_pointer_reg   = extra_pointer_reg;
    next_sp                  = sp;
    next_bank_pointer        = bank_pointer;
    next_condition_code_byte = condition_code_byte;
    next_gpr_sel             = gpr_sel;
    next_map_query           = map_query;
    if (access_wr) begin
      case (paddr)
        ccrf_pkg::OFS_PC:   next_pc = pwdata[15:0];
        ccrf_pkg::OFS_ACC:  next_acc = pwdata[15:0];
        ccrf_pkg::OFS_TMP:  next_tmp = pwdata[15:0];
        ccrf_pkg::OFS_IDX:  next_index_reg = pwdata[15:0];
        ccrf_pkg::OFS_EXP:  next_extra_pointer_reg = pwdata[15:0];
        ccrf_pkg::OFS_SP:   next_sp = pwdata[15:0];
        ccrf_pkg::OFS_PSW: begin
          next_bank_pointer        = pwdata[15:8];
          next_condition_code_byte = pwdata[7:0];
        end
        ccrf_pkg::OFS_GSEL: next_gpr_sel = pwdata[2:0];
        ccrf_pkg::OFS_MAPQ: next_map_query = pwdata[15:0];
        default: next_pc = pc;
      endcase
    end
    if (cmd_go) begin
      case (cmd_op)
        ccrf_pkg::CCRF_OP_NOP: next_pc = pc;
        ccrf_pkg::CCRF_OP_STEP: next_pc = pc + 16'h0001;
        default: begin
          // Byte results replace only the low byte of the accumulator.
          if (cmd_op != ccrf_pkg::CCRF_OP_CMP) begin
            next_acc = cmd_byte ? {acc[15:8], alu_result[7:0]} : alu_result;
          end
          if (alu_arith) begin
            next_condition_code_byte[ccrf_pkg::CC_H] = alu_h;
          end
          next_condition_code_byte[ccrf_pkg::CC_N] = alu_n;
          next_condition_code_byte[ccrf_pkg::CC_Z] = alu_z;
          next_condition_code_byte[ccrf_pkg::CC_V] = alu_v;
          next_condition_code_byte[ccrf_pkg::CC_C] = alu_c;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Next values of the bus answer and the presented addresses.
  // ----------------------------------------------------------------------
  always_comb begin
    next_pready  = setup;
    next_pslverr = setup & (~mapped | (pwrite & ~full_word));
    next_prdata  = 32'h0000_0000;
    if (setup & ~pwrite) begin
      case (paddr)
        ccrf_pkg::OFS_PC:     next_prdata = {16'h0000, pc};
        ccrf_pkg::OFS_ACC:    next_prdata = {16'h0000, acc};
        ccrf_pkg::OFS_TMP:    next_prdata = {16'h0000, tmp};
        ccrf_pkg::OFS_IDX:    next_prdata = {16'h0000, index_reg};
        ccrf_pkg::OFS_EXP:    next_prdata = {16'h0000, extra_pointer_reg};
        ccrf_pkg::OFS_SP:     next_prdata = {16'h0000, sp};
        ccrf_pkg::OFS_PSW:    next_prdata = {16'h0000, program_status_word};
        ccrf_pkg::OFS_GSEL:   next_prdata = {29'h0000_0000, gpr_sel};
        ccrf_pkg::OFS_GDATA:  next_prdata = {24'h00_0000, gpr_rd};
        ccrf_pkg::OFS_GPHYS:  next_prdata = {16'h0000, gpr_phys};
        ccrf_pkg::OFS_MAPQ:   next_prdata = {14'h0000, region, map_query};
        ccrf_pkg::OFS_STATUS: next_prdata = {31'h0000_0000, irq_accept};
        default:              next_prdata = 32'h0000_0000;
      endcase
    end
    // Indexed operand address uses the temporary low byte as displacement.
    next_operand_addr = index_reg + {8'h00, tmp[7:0]};
    // A request is serviced only when enabled and stronger than the level.
    next_irq_accept = irq_req & condition_code_byte[ccrf_pkg::CC_I]
                      & (irq_level < {condition_code_byte[ccrf_pkg::CC_IL1],
                                      condition_code_byte[ccrf_pkg::CC_IL0]});
  end

  // ----------------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------------
  // Reset clears the interrupt enable and opens at the weakest level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc                  <= ccrf_pkg::RST_WORD;
      acc                 <= ccrf_pkg::RST_WORD;
      tmp                 <= ccrf_pkg::RST_WORD;
      index_reg           <= ccrf_pkg::RST_WORD;
      extra_pointer_reg   <= ccrf_pkg::RST_WORD;
      sp                  <= ccrf_pkg::RST_WORD;
      bank_pointer        <= ccrf_pkg::RST_BANK;
      condition_code_byte <= ccrf_pkg::RST_CC;
      gpr_sel             <= 3'h0;
      map_query           <= ccrf_pkg::RST_WORD;
      prdata              <= 32'h0000_0000;
      pready              <= 1'b0;
      pslverr             <= 1'b0;
      irq_accept          <= 1'b0;
      operand_addr        <= ccrf_pkg::RST_WORD;
    end else begin
      pc                  <= next_pc;
      acc                 <= next_acc;
      tmp                 <= next_tmp;
      index_reg           <= next_index_reg;
      extra_pointer_reg   <= next_extra_pointer_reg;
      sp                  <= next_sp;
      bank_pointer        <= next_bank_pointer;
      condition_code_byte <= next_condition_code_byte;
      gpr_sel             <= next_gpr_sel;
      map_query           <= next_map_query;
      prdata              <= next_prdata;
      pready              <= next_pready;
      pslverr             <= next_pslverr;
      irq_accept          <= next_irq_accept;
      operand_addr        <= next_operand_addr;
    end
  end

  // Fetch, pointer and stack addresses are the pointer registers themselves.
  assign fetch_addr = pc;
  assign ptr_addr   = extra_pointer_reg;
  assign stack_addr = sp;

endmodule : ccrf_core

// File: bench/ccrf_monitor.sv
// Checker of the bus answer, interrupt decision and address outputs of the core.
`timescale 1ns/100ps
module ccrf_monitor (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Bus request and answer
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Interrupt judge and memory addresses
  input wire logic        irq_req,
  input wire logic [1:0]  irq_level,
  input wire logic        irq_accept,
  input wire logic [15:0] fetch_addr,
  input wire logic [15:0] operand_addr,
  input wire logic [15:0] ptr_addr,
  input wire logic [15:0] stack_addr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A write lands only when accepted; a refused one must leave state alone.
  logic acc_ok;
  logic wr_ok;
  assign acc_ok = psel && penable && pready;
  assign wr_ok  = acc_ok && pwrite && !pslverr;
  property p_wait; psel && !penable |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("no answer after setup");
  property p_pulse; pready |=> !pready && prdata == 32'h0; endproperty
  a_pulse: assert property (p_pulse) else $error("answer held too long");
  property p_ro;
    acc_ok && pwrite && (paddr == ccrf_pkg::OFS_GPHYS || pstrb != 4'hf) |-> pslverr;
  endproperty
  a_ro: assert property (p_ro) else $error("refused write not flagged");
  property p_unmap; acc_ok && paddr > ccrf_pkg::OFS_STATUS |-> pslverr; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access not flagged");
  property p_pc; wr_ok && paddr == ccrf_pkg::OFS_PC |=> fetch_addr == $past(pwdata[15:0]); endproperty
  a_pc: assert property (p_pc) else $error("fetch address missed write");
  property p_ptr; wr_ok && paddr == ccrf_pkg::OFS_EXP |=> ptr_addr == $past(pwdata[15:0]); endproperty
  a_ptr: assert property (p_ptr) else $error("pointer address missed write");
  property p_sp; wr_ok && paddr == ccrf_pkg::OFS_SP |=> stack_addr == $past(pwdata[15:0]); endproperty
  a_sp: assert property (p_sp) else $error("stack address missed write");
  property p_lvl3; $past(irq_level) == 2'h3 |-> !irq_accept; endproperty
  a_lvl3: assert property (p_lvl3) else $error("weakest level accepted");
  property p_noreq; !$past(irq_req) |-> !irq_accept; endproperty
  a_noreq: assert property (p_noreq) else $error("accept without request");
  // Main scenarios: commands run, refusals seen, an interrupt let through.
  c_cmd: cover property (wr_ok && paddr == ccrf_pkg::OFS_CMD);
  c_err: cover property (acc_ok && pslverr);
  c_irq: cover property (irq_accept);
endmodule : ccrf_monitor

// File: bench/testbench.sv
// Random self-checking bench of the core register set and condition-code logic.
`timescale 1ns/100ps
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, irq_req, irq_accept;
  logic [1:0]  irq_level;
  logic [3:0]  pstrb, op;
  logic [7:0]  paddr, cc, bk;
  logic [15:0] fetch_addr, operand_addr, ptr_addr, stack_addr, a, b;
  logic [15:0] v [6];
  logic [15:0] ma [6] = '{16'h007f, 16'h0080, 16'h3fff, 16'h4000, 16'hffbf, 16'hffc0};
  logic [1:0]  mr [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
  logic [23:0] e;
  logic [31:0] pwdata, prdata, rd;
  int          err_total, cmp_count;
  ccrf_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_req(irq_req), .irq_level(irq_level),
    .irq_accept(irq_accept), .fetch_addr(fetch_addr), .operand_addr(operand_addr),
    .ptr_addr(ptr_addr), .stack_addr(stack_addr));
  // Bus clock of 100 ns period.
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("mismatches %0d, compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  // One transfer; the request holds until pready is seen, a hang is cut short.
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                      input logic [3:0] st);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_total++;
        finish_test();
      end
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    xfer(1'b1, ad, wd, 4'hf);
    check(er, 1'b0);
  endtask : wr
  task automatic rdc(input logic [7:0] ad, input logic [31:0] ex);
    xfer(1'b0, ad, 32'h0, 4'h0);
    check(rd, ex);
  endtask : rdc
  // Byte-mode reference: new accumulator and flag byte; V is left 0 for shifts.
  function automatic logic [23:0] model(input logic [3:0] op, input logic [15:0] a,
                                        input logic [15:0] b, input logic [7:0] f);
    logic [8:0] r;
    case (op)
      4'h1: r = a[7:0] + b[7:0];
      4'h4: r = {1'b0, a[7:0] & b[7:0]};
      4'h5: r = {1'b0, a[7:0] | b[7:0]};
      4'h6: r = {1'b0, a[7:0] ^ b[7:0]};
      4'h7: r = {a[7:0], f[0]};
      4'h8: r = {a[0], f[0], a[7:1]};
      default: r = a[7:0] - b[7:0];
    endcase
    if (op < 4'h4) begin
      f[7] = (op == 4'h1) ? (a[3:0] + b[3:0]) > 5'h0f : a[3:0] < b[3:0];
      f[1] = (a[7] ^ b[7] ^ (op != 4'h1)) == 1'b0 && r[7] != a[7];
    end
    if (op < 4'h4 || op > 4'h6) f[0] = r[8];
    if (op > 4'h3) f[1] = 1'b0;
    f[3] = r[7];
    f[2] = r[7:0] == 8'h0;
    return {op == 4'h3 ? a : {a[15:8], r[7:0]}, f};
  endfunction : model
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb, irq_req, irq_level} = '0;
    presetn = 1'b0;
    err_total = 0;
    cmp_count = 0;
    void'($urandom(32'h61bffc84));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(ccrf_pkg::OFS_PSW, 32'h30);
    // Dedicated registers take random words; only the low half comes back.
    for (int i = 0; i < 6; i++) begin
      v[i] = 16'($urandom);
      wr(8'(4 * i), {16'($urandom), v[i]});
      rdc(8'(4 * i), {16'h0, v[i]});
    end
    check(fetch_addr, v[0]);
    check(operand_addr, 16'(v[3] + v[2][7:0]));
    check(ptr_addr, v[4]);
    check(stack_addr, v[5]);
    wr(ccrf_pkg::OFS_CMD, 32'h9);
    rdc(ccrf_pkg::OFS_PC, {16'h0, v[0] + 16'h1});
    // Byte operations with equal operands and sign-edge values among random ones.
    for (int i = 0; i < 40; i++) begin
      op = 4'(i % 8 + 1);
      a = 16'($urandom);
      b = 16'($urandom);
      cc = 8'($urandom);
      bk = 8'($urandom);
      if (i < 8) b[7:0] = a[7:0];
      if (i >= 8 && i < 16) a[7:0] = 8'h80;
      wr(ccrf_pkg::OFS_ACC, {16'h0, a});
      wr(ccrf_pkg::OFS_TMP, {16'h0, b});
      wr(ccrf_pkg::OFS_PSW, {16'h0, bk, cc});
      wr(ccrf_pkg::OFS_CMD, {23'h0, 1'b1, 4'h0, op});
      e = model(op, a, b, cc);
      rdc(ccrf_pkg::OFS_ACC, {16'h0, e[23:8]});
      xfer(1'b0, ccrf_pkg::OFS_PSW, 32'h0, 4'h0);
      check(rd, {16'h0, bk, e[7:0]});
    end
    // Word-mode add of two most negative words: zero, carry and overflow.
    wr(ccrf_pkg::OFS_ACC, 32'h8000);
    wr(ccrf_pkg::OFS_TMP, 32'h8000);
    wr(ccrf_pkg::OFS_PSW, 32'h0);
    wr(ccrf_pkg::OFS_CMD, 32'h1);
    rdc(ccrf_pkg::OFS_ACC, 32'h0);
    rdc(ccrf_pkg::OFS_PSW, 32'h7);
    // Banks sharing a register number must not alias; written first, then read.
    for (int i = 0; i < 8; i++) begin
      bk = 8'(i % 4 * 10 + 1);
      wr(ccrf_pkg::OFS_PSW, {16'h0, bk, 8'h30});
      wr(ccrf_pkg::OFS_GSEL, 32'(i % 2 * 7));
      if (i < 4) wr(ccrf_pkg::OFS_GDATA, {24'h0, bk ^ 8'h5a});
      else rdc(ccrf_pkg::OFS_GDATA, {24'h0, bk ^ 8'h5a});
      rdc(ccrf_pkg::OFS_GPHYS, 32'h100 + bk * 8 + i % 2 * 7);
    end
    // Region edges of the address space.
    foreach (ma[j]) begin
      wr(ccrf_pkg::OFS_MAPQ, {16'h0, ma[j]});
      rdc(ccrf_pkg::OFS_MAPQ, {14'h0, mr[j], ma[j]});
    end
    // Refused accesses answer with an error and leave the counter alone.
    xfer(1'b1, ccrf_pkg::OFS_GPHYS, 32'h1, 4'hf);
    check(er, 1'b1);
    xfer(1'b1, ccrf_pkg::OFS_PC, 32'h0, 4'h3);
    check(er, 1'b1);
    xfer(1'b0, 8'h34, 32'h0, 4'h0);
    check({er, rd[30:0]}, 32'h80000000);
    rdc(ccrf_pkg::OFS_PC, {16'h0, v[0] + 16'h1});
    // Every level against every permitted level, interrupts on or off.
    for (int i = 0; i < 16; i++) begin
      cc = {1'b0, 1'($urandom), 2'(i / 4), 4'h0};
      irq_level <= 2'(i);
      irq_req <= (i != 5);
      wr(ccrf_pkg::OFS_PSW, {24'h0, cc});
      rdc(ccrf_pkg::OFS_STATUS, {31'h0, irq_req && cc[6] && irq_level < cc[5:4]});
    end
    finish_test();
  end
endmodule : testbench
bind ccrf_core ccrf_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_req(irq_req),
  .irq_level(irq_level), .irq_accept(irq_accept), .fetch_addr(fetch_addr),
  .operand_addr(operand_addr), .ptr_addr(ptr_addr), .stack_addr(stack_addr));
